// ===== serial_cmd_port.sv
// Command port and daughter-card port sharing one command framer.
// Assumes an interpreter behind the cmd/reply/settings ports.
`timescale 1ns/1ps
`include "serial_cfg_map.svh"
// Operation
// - Setting writes are stored; applied only at the next power-up.
// - Per-port enable; command port on, daughter port off by default.
// - One framer; other port ignored until the locking port's CR.
// - Node address 0..31, default 0.
// - Nonzero address: unprefixed commands dropped with no reply.
// - Rate codes 1..7 select 9600 up to 230400 bit/s.
// - Rate default 2 command port, 7 daughter port.
// - Parity codes 0..4: none, odd, even, mark, zero; default none.
// - Eight data bits without parity, seven with; one stop bit.
// - Flow 0 none, 1 XON/XOFF, 2 RTS/CTS; RTS/CTS off on command port in RS-485.
// - Flow default 0 command port, 2 daughter port.
// - Commands are ASCII ending in CR; letters case-insensitive.
// - Set answered ok CR LF; get answered lower-case text CR LF.
// - Star prefix is a broadcast to every node.
// - No prefix means address 0.
module serial_cmd_port
   import serial_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Supply restart with retained settings, RS-485 wiring
   input  wire logic       powerUp,
   input  wire logic       rs485Sel,
   // Serial pins, index 0 command port, 1 daughter port
   input  wire logic [1:0] rxPin,
   input  wire logic [1:0] ctsPin,
   output logic      [1:0] txPin,
   output logic      [1:0] rtsPin,
   // Accepted command characters
   output logic            cmdValid,
   output logic [7:0]      cmdChar,
   output logic            cmdLast,
   output logic            cmdPort,
   // Replies from the interpreter
   input  wire logic       replyOk,
   input  wire logic       respValid,
   input  wire logic [7:0] respChar,
   input  wire logic       respLast,
   output logic            respReady,
   // Settings store
   input  wire logic       cfgWr,
   input  wire logic       cfgPort,
   input  wire logic [2:0] cfgSel,
   input  wire logic [7:0] cfgData,
   output logic            cfgAck,
   output logic            cfgBad,
   output logic [7:0]      cfgRdData,
   // Framer state
   output logic            lockBusy,
   output logic            lockPort
);

   logic [7:0] st_r [2][5];
   logic [7:0] st_nxt [2][5];
   logic [7:0] ac_r [2][5];
   logic [7:0] ac_nxt [2][5];
   logic [1:0] rxV, txRdy, txV;
   logic [7:0] rxD [2];
   logic [7:0] ch, lc, addrAcc_r, addrAcc_nxt, txD, rdVal;
   logic       chV, chP, star_r, star_nxt, match;
   logic       lockBusy_nxt, lockPort_nxt, cmdValid_nxt, cmdLast_nxt;
   logic       cmdPort_nxt, tailBusy_r, tailBusy_nxt, replyPort_r;
   logic       replyPort_nxt, respReady_nxt, sent, cfgOk;
   logic [7:0] cmdChar_nxt;
   logic [1:0] tailIdx_r, tailIdx_nxt;
   parse_state_type pst_r, pst_nxt;

   // Power-up defaults per port and setting
   function automatic logic [7:0] dflt(input int p, input int s);
      case (s)
         0:       dflt = (p == 0) ? `ENBL_DEF_CMD : `ENBL_DEF_DC;
         2:       dflt = (p == 0) ? `RATE_DEF_CMD : `RATE_DEF_DC;
         4:       dflt = (p == 0) ? `FLOW_DEF_CMD : `FLOW_DEF_DC;
         3:       dflt = `PAR_DEF;
         default: dflt = `ADDR_DEF;
      endcase
   endfunction

   // Range check; out-of-range writes leave the store untouched
   always_comb
   begin
      case (cfgSel)
         SEL_ENABLE: cfgOk = cfgData <= `ENBL_MAX;
         SEL_ADDR:   cfgOk = cfgData <= `ADDR_MAX;
         SEL_RATE:   cfgOk = cfgData >= `RATE_MIN && cfgData <= `RATE_MAX;
         SEL_PARITY: cfgOk = cfgData <= `PAR_MAX;
         SEL_FLOW:   cfgOk = cfgData <= `FLOW_MAX;
         default:    cfgOk = 1'b0;
      endcase
      rdVal = (cfgSel <= 3'h4) ? st_r[cfgPort][cfgSel] : 8'h00;
   end

   // store on write, apply on power-up only
   always_comb
   begin
      st_nxt = st_r;
      ac_nxt = powerUp ? st_r : ac_r;
      if (cfgWr && cfgOk)
      begin
         st_nxt[cfgPort][cfgSel] = cfgData;
      end
   end

   // Two line engines
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gLine
         uart_port uPort (
            .clk     (clk),
            .rst     (rst),
            .rate    (ac_r[g][SEL_RATE]),
            .parity  (ac_r[g][SEL_PARITY]),
            // RTS/CTS unused on the command port (line 0) when wired for RS-485
            .hwFlow  (ac_r[g][SEL_FLOW] == `FLOW_HW && !(g == 0 && rs485Sel)),
            .swFlow  (ac_r[g][SEL_FLOW] == `FLOW_SW),
            .holdOff (lockBusy && lockPort != g),
            .rxPin   (rxPin[g]),
            .ctsPin  (ctsPin[g]),
            .txPin   (txPin[g]),
            .rtsPin  (rtsPin[g]),
            .rxValid (rxV[g]),
            .rxData  (rxD[g]),
            .txValid (txV[g]),
            .txData  (txD),
            .txReady (txRdy[g])
         );
         assign txV[g] = sent && (replyPort_r == g);
      end
   endgenerate

   // only the locking port feeds the framer; enables
   always_comb
   begin
      chV = 1'b0;
      chP = 1'b0;
      if (lockBusy)
      begin
         chV = rxV[lockPort] && ac_r[lockPort][SEL_ENABLE][0];
         chP = lockPort;
      end
      else if (rxV[0] && ac_r[0][SEL_ENABLE][0])
      begin
         chV = 1'b1;
      end
      else
      begin
         chV = rxV[1] && ac_r[1][SEL_ENABLE][0];
         chP = 1'b1;
      end
      ch = rxD[chP];
      lc = (ch >= `CH_UA && ch <= `CH_UZ) ? (ch | 8'h20) : ch;
   end

   // Command framer with address prefix filter
   always_comb
   begin
      pst_nxt       = pst_r;
      lockBusy_nxt  = lockBusy;
      lockPort_nxt  = lockPort;
      addrAcc_nxt   = addrAcc_r;
      star_nxt      = star_r;
      cmdValid_nxt  = 1'b0;
      cmdLast_nxt   = 1'b0;
      cmdChar_nxt   = cmdChar;
      cmdPort_nxt   = cmdPort;
      // star matches any node; prefix against own address
      match = star_r || addrAcc_r == ac_r[lockPort][SEL_ADDR];
      if (chV)
      begin
         unique case (pst_r)
            P_FIRST:
               if (ch != `CH_CR && ch != `CH_LF)
               begin
                  lockBusy_nxt = 1'b1;
                  lockPort_nxt = chP;
                  cmdChar_nxt  = lc;
                  cmdPort_nxt  = chP;
                  addrAcc_nxt  = 8'h00;
                  star_nxt     = 1'b0;
                  if (ch == `CH_LBR)
                  begin
                     pst_nxt = P_ADDR;
                  end
                  // no prefix counts as address 0
                  else if (ac_r[chP][SEL_ADDR] == `ADDR_DEF)
                  begin
                     pst_nxt      = P_BODY;
                     cmdValid_nxt = 1'b1;
                  end
                  else
                  begin
                     pst_nxt = P_SKIP;
                  end
               end
            P_ADDR:
               if (ch == `CH_RBR)
               begin
                  pst_nxt = match ? P_BODY : P_SKIP;
               end
               else if (ch == `CH_CR)
               begin
                  pst_nxt      = P_FIRST;
                  lockBusy_nxt = 1'b0;
               end
               else if (ch == `CH_STAR)
               begin
                  star_nxt = 1'b1;
               end
               else
               begin
                  addrAcc_nxt = 8'((addrAcc_r << 3) + (addrAcc_r << 1)
                                   + (ch - `CH_ZERO));
               end
            P_BODY:
            begin
               cmdValid_nxt = 1'b1;
               cmdChar_nxt  = lc;
               if (ch == `CH_CR)
               begin
                  cmdLast_nxt  = 1'b1;
                  pst_nxt      = P_FIRST;
                  lockBusy_nxt = 1'b0;
               end
            end
            P_SKIP:
               if (ch == `CH_CR)
               begin
                  pst_nxt      = P_FIRST;
                  lockBusy_nxt = 1'b0;
               end
         endcase
      end
   end

   // reply sender: ok CR LF, or text then CR LF
   always_comb
   begin
      tailBusy_nxt  = tailBusy_r;
      tailIdx_nxt   = tailIdx_r;
      replyPort_nxt = (cmdValid && cmdLast) ? cmdPort : replyPort_r;
      sent          = 1'b0;
      txD           = 8'h00;
      if (tailBusy_r)
      begin
         sent = txRdy[replyPort_r];
         case (tailIdx_r)
            2'h0:    txD = `CH_O;
            2'h1:    txD = `CH_K;
            2'h2:    txD = `CH_CR;
            default: txD = `CH_LF;
         endcase
         if (sent)
         begin
            tailIdx_nxt  = tailIdx_r + 2'h1;
            tailBusy_nxt = (tailIdx_r != 2'h3);
         end
      end
      else if (replyOk)
      begin
         tailBusy_nxt = 1'b1;
         tailIdx_nxt  = 2'h0;
      end
      else if (respValid && respReady)
      begin
         sent = 1'b1;
         // Keyword letters go out in lower case
         txD  = (respChar >= `CH_UA && respChar <= `CH_UZ)
                ? (respChar | 8'h20) : respChar;
         if (respLast)
         begin
            tailBusy_nxt = 1'b1;
            tailIdx_nxt  = 2'h2;
         end
      end
      respReady_nxt = !tailBusy_nxt && !replyOk && !sent
                      && txRdy[replyPort_nxt];
   end

   // State registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int p = 0; p < 2; p++)
         begin
            for (int s = 0; s < 5; s++)
            begin
               st_r[p][s] <= dflt(p, s);
               ac_r[p][s] <= dflt(p, s);
            end
         end
         pst_r       <= P_FIRST;
         lockBusy    <= 1'b0;
         lockPort    <= 1'b0;
         addrAcc_r   <= 8'h00;
         star_r      <= 1'b0;
         cmdValid    <= 1'b0;
         cmdLast     <= 1'b0;
         cmdChar     <= 8'h00;
         cmdPort     <= 1'b0;
         tailBusy_r  <= 1'b0;
         tailIdx_r   <= 2'h0;
         replyPort_r <= 1'b0;
         respReady   <= 1'b0;
         cfgAck      <= 1'b0;
         cfgBad      <= 1'b0;
         cfgRdData   <= 8'h00;
      end
      else
      begin
         st_r        <= st_nxt;
         ac_r        <= ac_nxt;
         pst_r       <= pst_nxt;
         lockBusy    <= lockBusy_nxt;
         lockPort    <= lockPort_nxt;
         addrAcc_r   <= addrAcc_nxt;
         star_r      <= star_nxt;
         cmdValid    <= cmdValid_nxt;
         cmdLast     <= cmdLast_nxt;
         cmdChar     <= cmdChar_nxt;
         cmdPort     <= cmdPort_nxt;
         tailBusy_r  <= tailBusy_nxt;
         tailIdx_r   <= tailIdx_nxt;
         replyPort_r <= replyPort_nxt;
         respReady   <= respReady_nxt;
         cfgAck      <= cfgWr;
         cfgBad      <= cfgWr && !cfgOk;
         cfgRdData   <= rdVal;
      end
   end

endmodule

// ===== serial_cfg_map.svh
// Constants for the dual ASCII command serial port block.
// Assumes a 125 MHz system clock; included by its bare name.
`ifndef SERIAL_CFG_MAP_SVH
`define SERIAL_CFG_MAP_SVH

// Clock rate and selectable line rates in bits per second
`define CLK_HZ 125000000
`define RATE_1 9600
`define RATE_2 19200
`define RATE_3 28800
`define RATE_4 38400
`define RATE_5 57600
`define RATE_6 115200
`define RATE_7 230400
`define BAUD_DIV(rate) (`CLK_HZ / (rate))

// Setting ranges and power-up defaults
`define ENBL_DEF_CMD 8'h01
`define ENBL_DEF_DC  8'h00
`define ENBL_MAX     8'h01
`define ADDR_DEF     8'h00
`define ADDR_MAX     8'h1f
`define RATE_DEF_CMD 8'h02
`define RATE_DEF_UI  8'h06
`define RATE_DEF_DC  8'h07
`define RATE_MIN     8'h01
`define RATE_MAX     8'h07
`define PAR_DEF      8'h00
`define PAR_MAX      8'h04
`define FLOW_DEF_CMD 8'h00
`define FLOW_DEF_DC  8'h02
`define FLOW_SW      8'h01
`define FLOW_HW      8'h02
`define FLOW_MAX     8'h02

// Frame sizes
`define DBITS_NOPAR 4'h8
`define DBITS_PAR   4'h7

// Characters of the command language
`define CH_CR   8'h0d
`define CH_LF   8'h0a
`define CH_LBR  8'h5b
`define CH_RBR  8'h5d
`define CH_STAR 8'h2a
`define CH_ZERO 8'h30
`define CH_UA   8'h41
`define CH_UZ   8'h5a
`define CH_O    8'h6f
`define CH_K    8'h6b
`define CH_XON  8'h11
`define CH_XOFF 8'h13
`define CASE_BIT 5

`endif

// ===== serial_cfg_pkg.sv
// Types for the dual ASCII command serial port block.
// Assumes nothing of its surroundings.
package serial_cfg_pkg;

   // Character engine states, one-hot
   typedef enum logic [4:0] {
      U_IDLE  = 5'b00001,
      U_START = 5'b00010,
      U_DATA  = 5'b00100,
      U_PAR   = 5'b01000,
      U_STOP  = 5'b10000
   } uart_state_type;

   // Command framing states, one-hot
   typedef enum logic [3:0] {
      P_FIRST = 4'b0001,
      P_ADDR  = 4'b0010,
      P_BODY  = 4'b0100,
      P_SKIP  = 4'b1000
   } parse_state_type;

   // Setting selector on the settings write port
   typedef enum logic [2:0] {
      SEL_ENABLE = 3'h0,
      SEL_ADDR   = 3'h1,
      SEL_RATE   = 3'h2,
      SEL_PARITY = 3'h3,
      SEL_FLOW   = 3'h4
   } cfg_sel_type;

   // Parity selector codes
   typedef enum logic [2:0] {
      PAR_NONE = 3'h0,
      PAR_ODD  = 3'h1,
      PAR_EVEN = 3'h2,
      PAR_MARK = 3'h3,
      PAR_ZERO = 3'h4
   } parity_type;

endpackage

// ===== uart_port.sv
// One serial line: receiver, transmitter, RTS/CTS and XON/XOFF.
// Assumes settings stay static between power-up loads.
`timescale 1ns/1ps
`include "serial_cfg_map.svh"
module uart_port
   import serial_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Active settings
   input  wire logic [7:0] rate,
   input  wire logic [7:0] parity,
   input  wire logic       hwFlow,
   input  wire logic       swFlow,
   input  wire logic       holdOff,
   // Pins
   input  wire logic       rxPin,
   input  wire logic       ctsPin,
   output logic            txPin,
   output logic            rtsPin,
   // Character streams
   output logic            rxValid,
   output logic [7:0]      rxData,
   input  wire logic       txValid,
   input  wire logic [7:0] txData,
   output logic            txReady
);

   uart_state_type rxSt_r, rxSt_nxt, txSt_r, txSt_nxt;
   logic [15:0] rxCnt_r, rxCnt_nxt, txCnt_r, txCnt_nxt, div;
   logic [3:0]  rxIdx_r, rxIdx_nxt, txIdx_r, txIdx_nxt, dBits;
   logic [7:0]  rxSh_r, rxSh_nxt, txSh_r, txSh_nxt, rxData_nxt;
   logic [2:0]  rxSync_r, ctsSync_r;
   logic        rxLine_r, rxLine_nxt, ctsLine_r, ctsLine_nxt;
   logic        rxValid_nxt, paused_r, paused_nxt, txPin_nxt;
   logic        txReady_nxt, parBit, blocked, rtsPin_nxt;

   // Rate code to bit period in clocks
   always_comb
   begin
      case (rate)
         8'h01:   div = 16'(`BAUD_DIV(`RATE_1));
         8'h02:   div = 16'(`BAUD_DIV(`RATE_2));
         8'h03:   div = 16'(`BAUD_DIV(`RATE_3));
         8'h04:   div = 16'(`BAUD_DIV(`RATE_4));
         8'h05:   div = 16'(`BAUD_DIV(`RATE_5));
         8'h06:   div = 16'(`BAUD_DIV(`RATE_6));
         8'h07:   div = 16'(`BAUD_DIV(`RATE_7));
         default: div = 16'(`BAUD_DIV(`RATE_2));
      endcase
   end

   assign dBits = (parity == `PAR_DEF) ? `DBITS_NOPAR : `DBITS_PAR;
   // Parity over the seven data bits
   always_comb
   begin
      case (parity[2:0])
         PAR_ODD:  parBit = ~^txSh_r[6:0];
         PAR_EVEN: parBit = ^txSh_r[6:0];
         PAR_MARK: parBit = 1'b1;
         default:  parBit = 1'b0;
      endcase
   end
   assign blocked    = (hwFlow && !ctsLine_r) || (swFlow && paused_r);
   assign rtsPin_nxt = hwFlow ? !holdOff : 1'b1;
   // Pins count once the second and third stages agree
   assign rxLine_nxt  = (rxSync_r[1] == rxSync_r[2]) ? rxSync_r[2]
                                                     : rxLine_r;
   assign ctsLine_nxt = (ctsSync_r[1] == ctsSync_r[2]) ? ctsSync_r[2]
                                                       : ctsLine_r;

   // Receiver; parity is not checked, a bad stop bit drops the char
   always_comb
   begin
      rxSt_nxt    = rxSt_r;
      rxCnt_nxt   = (rxCnt_r == 16'h0000) ? div - 16'h0001
                                          : rxCnt_r - 16'h0001;
      rxIdx_nxt   = rxIdx_r;
      rxSh_nxt    = rxSh_r;
      rxValid_nxt = 1'b0;
      rxData_nxt  = rxData;
      paused_nxt  = swFlow ? paused_r : 1'b0;
      unique case (rxSt_r)
         U_IDLE:
         begin
            rxCnt_nxt = {1'b0, div[15:1]};
            if (!rxLine_r)
            begin
               rxSt_nxt = U_START;
            end
         end
         U_START:
            if (rxCnt_r == 16'h0000)
            begin
               rxSt_nxt  = rxLine_r ? U_IDLE : U_DATA;
               rxIdx_nxt = 4'h0;
               rxSh_nxt  = 8'h00;
            end
         U_DATA:
            if (rxCnt_r == 16'h0000)
            begin
               rxSh_nxt[rxIdx_r[2:0]] = rxLine_r;
               rxIdx_nxt = rxIdx_r + 4'h1;
               if (rxIdx_r == dBits - 4'h1)
               begin
                  rxSt_nxt = (parity == `PAR_DEF) ? U_STOP : U_PAR;
               end
            end
         U_PAR:
            if (rxCnt_r == 16'h0000)
            begin
               rxSt_nxt = U_STOP;
            end
         U_STOP:
            if (rxCnt_r == 16'h0000)
            begin
               rxSt_nxt = U_IDLE;
               if (rxLine_r && swFlow && rxSh_r == `CH_XOFF)
               begin
                  paused_nxt = 1'b1;
               end
               else if (rxLine_r && swFlow && rxSh_r == `CH_XON)
               begin
                  paused_nxt = 1'b0;
               end
               else if (rxLine_r)
               begin
                  rxValid_nxt = 1'b1;
                  rxData_nxt  = rxSh_r;
               end
            end
      endcase
   end

   // Transmitter; start waits while flow control holds the line
   always_comb
   begin
      txSt_nxt  = txSt_r;
      txCnt_nxt = (txCnt_r == 16'h0000) ? div - 16'h0001
                                        : txCnt_r - 16'h0001;
      txIdx_nxt = txIdx_r;
      txSh_nxt  = txSh_r;
      txPin_nxt = txPin;
      unique case (txSt_r)
         U_IDLE:
         begin
            txPin_nxt = 1'b1;
            txCnt_nxt = div - 16'h0001;
            if (txValid && txReady)
            begin
               txSt_nxt  = U_START;
               txSh_nxt  = txData;
               txPin_nxt = 1'b0;
               txIdx_nxt = 4'h0;
            end
         end
         U_START:
            if (txCnt_r == 16'h0000)
            begin
               txSt_nxt  = U_DATA;
               txPin_nxt = txSh_r[0];
            end
         U_DATA:
            if (txCnt_r == 16'h0000)
            begin
               txIdx_nxt = txIdx_r + 4'h1;
               txPin_nxt = txSh_r[txIdx_nxt[2:0]];
               if (txIdx_r == dBits - 4'h1)
               begin
                  txSt_nxt  = (parity == `PAR_DEF) ? U_STOP : U_PAR;
                  txPin_nxt = (parity == `PAR_DEF) ? 1'b1 : parBit;
               end
            end
         U_PAR:
            if (txCnt_r == 16'h0000)
            begin
               txSt_nxt  = U_STOP;
               txPin_nxt = 1'b1;
            end
         U_STOP:
            if (txCnt_r == 16'h0000)
            begin
               txSt_nxt = U_IDLE;
            end
      endcase
      txReady_nxt = (txSt_nxt == U_IDLE) && !blocked;
   end

   // State registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rxSync_r  <= 3'h7;
         ctsSync_r <= 3'h0;
         rxLine_r  <= 1'b1;
         ctsLine_r <= 1'b0;
         rxSt_r    <= U_IDLE;
         rxCnt_r   <= 16'h0000;
         rxIdx_r   <= 4'h0;
         rxSh_r    <= 8'h00;
         rxValid   <= 1'b0;
         rxData    <= 8'h00;
         paused_r  <= 1'b0;
         txSt_r    <= U_IDLE;
         txCnt_r   <= 16'h0000;
         txIdx_r   <= 4'h0;
         txSh_r    <= 8'h00;
         txPin     <= 1'b1;
         txReady   <= 1'b0;
         rtsPin    <= 1'b1;
      end
      else
      begin
         rxSync_r  <= {rxSync_r[1:0], rxPin};
         ctsSync_r <= {ctsSync_r[1:0], ctsPin};
         rxLine_r  <= rxLine_nxt;
         ctsLine_r <= ctsLine_nxt;
         rxSt_r    <= rxSt_nxt;
         rxCnt_r   <= rxCnt_nxt;
         rxIdx_r   <= rxIdx_nxt;
         rxSh_r    <= rxSh_nxt;
         rxValid   <= rxValid_nxt;
         rxData    <= rxData_nxt;
         paused_r  <= paused_nxt;
         txSt_r    <= txSt_nxt;
         txCnt_r   <= txCnt_nxt;
         txIdx_r   <= txIdx_nxt;
         txSh_r    <= txSh_nxt;
         txPin     <= txPin_nxt;
         txReady   <= txReady_nxt;
         rtsPin    <= rtsPin_nxt;
      end
   end

endmodule

// ===== serial_cmd_port_asserts.sv
// Checker for the dual command serial port block.
// Assumes it is bound to serial_cmd_port and sees only its ports.
`timescale 1ns/1ps
module serial_cmd_port_asserts
   import serial_cfg_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Settings store
   input wire logic       cfgWr,
   input wire logic [2:0] cfgSel,
   input wire logic [7:0] cfgData,
   input wire logic       cfgAck,
   input wire logic       cfgBad,
   // Command stream and framer lock
   input wire logic       cmdValid,
   input wire logic [7:0] cmdChar,
   input wire logic       cmdLast,
   input wire logic       cmdPort,
   input wire logic       lockBusy,
   input wire logic       lockPort
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_write_acked: assert property (cfgWr |=> cfgAck)
      else $error("write not acknowledged");
   chk_ack_cause: assert property (cfgAck |-> $past(cfgWr))
      else $error("acknowledge without write");
   chk_bad_acked: assert property (cfgBad |-> cfgAck)
      else $error("refusal without acknowledge");
   chk_addr_range: assert property (cfgWr && cfgSel == SEL_ADDR
      && cfgData > 8'h1f |=> cfgBad) else $error("address accepted");
   chk_rate_range: assert property (cfgWr && cfgSel == SEL_RATE
      && (cfgData == 8'h00 || cfgData > 8'h07) |=> cfgBad)
      else $error("rate code accepted");
   chk_parity_ok: assert property (cfgWr && cfgSel == SEL_PARITY
      && cfgData <= 8'h04 |=> !cfgBad) else $error("parity refused");
   chk_last_cr: assert property (cmdLast |->
      cmdValid && cmdChar == 8'h0d) else $error("end is not CR");
   chk_fold_case: assert property (cmdValid |->
      !(cmdChar inside {[8'h41:8'h5a]})) else $error("upper case");
   chk_lock_owner: assert property (cmdValid && lockBusy |->
      cmdPort == lockPort) else $error("char from other port");
   chk_lock_free: assert property (cmdLast |-> ##[0:1] !lockBusy)
      else $error("lock kept after CR");

   // Main scenarios reached
   cover property (cmdLast);
   cover property (cfgBad);
   cover property ($rose(lockBusy));
endmodule

// ===== serial_host.sv
// Host model on one serial line, 8N1 at the fast rate.
// Assumes the device port runs rate code 7 with parity off.
`timescale 1ns/1ps
module serial_host
(
   // Clock
   input  wire logic clk,
   // Lines
   input  wire logic fromDev,
   output logic      toDev
);
   // same rate and frame as device
   localparam int BitCyc = 542; // 125 MHz over 230400, truncated
   initial toDev = 1'b1;
   // start low, LSB first, stop high
   task automatic put(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         toDev <= f[i];
         repeat (BitCyc) @(posedge clk);
      end
   endtask
   // sample each bit at its centre, then skip the stop bit
   task automatic get(output logic [7:0] c);
      while (fromDev !== 1'b0)
         @(posedge clk);
      repeat (BitCyc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BitCyc) @(posedge clk);
         c[i] = fromDev;
      end
      repeat (BitCyc) @(posedge clk);
   endtask
endmodule

// ===== tb_serial_cmd_port.sv
// Bench for the dual command serial port block.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
module tb_serial_cmd_port import serial_cfg_pkg::*;;
   logic       clk = 1'b0, rst = 1'b1;
   logic       powerUp = 1'b0, replyOk = 1'b0, respValid = 1'b0;
   logic       cfgWr = 1'b0, cfgPort = 1'b0, respLast = 1'b1;
   logic [2:0] cfgSel = 3'h0;
   logic [7:0] cfgData = 8'h00, respChar = 8'h41;
   wire  [1:0] rxPin;
   logic [1:0] txPin, rtsPin;
   logic       cmdValid, cmdLast, cmdPort, respReady;
   logic       cfgAck, cfgBad, lockBusy, lockPort;
   logic [7:0] cmdChar, cfgRdData, c;
   int         error_cnt = 0, samples_checked = 0;
   logic [8:0] got[$], expq[4] = '{9'h061, 9'h00d, 9'h163, 9'h10d};
   logic [7:0] defs[2][5] = '{'{8'h01, 8'h00, 8'h02, 8'h00, 8'h00},
                              '{8'h00, 8'h00, 8'h07, 8'h00, 8'h02}};
   logic [7:0] tail[6] = '{8'h6f, 8'h6b, 8'h0d, 8'h0a, 8'h61, 8'h0d};
   logic [7:0] seq0[6] = '{8'h5a, 8'h0d, 8'h5b, 8'h34, 8'h5d, 8'h41};

   always #4 clk = ~clk;

   // Device, hosts on both lines; replies by ok tail and by text
   serial_cmd_port DUT (.clk(clk), .rst(rst), .powerUp(powerUp),
      .rs485Sel(1'b0), .rxPin(rxPin), .ctsPin(2'b11), .txPin(txPin),
      .rtsPin(rtsPin), .cmdValid(cmdValid), .cmdChar(cmdChar),
      .cmdLast(cmdLast), .cmdPort(cmdPort), .replyOk(replyOk),
      .respValid(respValid), .respChar(respChar), .respLast(respLast),
      .respReady(respReady), .cfgWr(cfgWr), .cfgPort(cfgPort),
      .cfgSel(cfgSel), .cfgData(cfgData), .cfgAck(cfgAck),
      .cfgBad(cfgBad), .cfgRdData(cfgRdData), .lockBusy(lockBusy),
      .lockPort(lockPort));
   serial_host h0 (.clk(clk), .fromDev(txPin[0]), .toDev(rxPin[0]));
   serial_host h1 (.clk(clk), .fromDev(txPin[1]), .toDev(rxPin[1]));

   // Collect command characters; drop the text request once taken
   always @(posedge clk)
      if (cmdValid === 1'b1)
         got.push_back({cmdPort, cmdChar});
   always @(posedge clk)
      if (respValid && respReady === 1'b1)
         respValid <= 1'b0;

   task automatic chk(input string n, input logic [8:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         $display("BAD %s exp %h got %h", n, e, g);
         error_cnt++;
      end
   endtask

   task automatic wr(input logic p, input logic [2:0] s,
                     input logic [7:0] d, input logic bad);
      @(posedge clk);
      cfgWr   <= 1'b1;
      cfgPort <= p;
      cfgSel  <= s;
      cfgData <= d;
      @(posedge clk);
      cfgWr <= 1'b0;
      #1;
      chk("cfgAck", 9'h001, {8'h00, cfgAck});
      chk("cfgBad", {8'h00, bad}, {8'h00, cfgBad});
   endtask

   task automatic rd(input logic p, input logic [2:0] s, input logic [7:0] e);
      @(posedge clk);
      cfgPort <= p;
      cfgSel  <= s;
      repeat (2) @(posedge clk);
      #1;
      chk("cfgRdData", {1'b0, e}, {1'b0, cfgRdData});
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Cut a hang; the tests need about 87k cycles
   initial
   begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int p = 0; p < 2; p++)
         for (int s = 0; s < 5; s++)
            rd(p[0], s[2:0], defs[p][s]);
      rd(1'b0, 3'h5, 8'h00);
      $display("test defaults done");
      wr(1'b0, SEL_ADDR, 8'h20, 1'b1);
      wr(1'b0, SEL_RATE, 8'h00, 1'b1);
      wr(1'b0, SEL_RATE, 8'h08, 1'b1);
      wr(1'b0, SEL_FLOW, 8'h03, 1'b1);
      wr(1'b0, SEL_ENABLE, 8'h02, 1'b1);
      for (int v = 0; v < 5; v++)
      begin
         wr(1'b1, SEL_PARITY, v[7:0], 1'b0);
         rd(1'b1, SEL_PARITY, v[7:0]);
      end
      wr(1'b1, SEL_PARITY, 8'h00, 1'b0);
      wr(1'b0, SEL_RATE, 8'h07, 1'b0);
      wr(1'b0, SEL_ADDR, 8'h04, 1'b0);
      wr(1'b0, SEL_FLOW, 8'h02, 1'b0);
      wr(1'b1, SEL_ENABLE, 8'h01, 1'b0);
      rd(1'b0, SEL_ADDR, 8'h04);
      $display("test settings done");
      @(posedge clk);
      powerUp <= 1'b1;
      @(posedge clk);
      powerUp <= 1'b0;
      foreach (seq0[i])
         h0.put(seq0[i]);
      h1.put(8'h62);
      h0.put(8'h0d);
      h1.put(8'h63);
      h1.put(8'h0d);
      repeat (20) @(posedge clk);
      chk("count", 9'h004, 9'(got.size()));
      foreach (expq[i])
         chk("cmd", expq[i], got[i]);
      $display("test commands done");
      replyOk <= 1'b1;
      @(posedge clk);
      replyOk <= 1'b0;
      respValid <= 1'b1;
      foreach (tail[i])
      begin
         h1.get(c);
         chk("reply", {1'b0, tail[i]}, {1'b0, c});
      end
      $display("test reply done");
      tally_and_finish();
   end
endmodule

bind serial_cmd_port serial_cmd_port_asserts chk_i (.clk(clk), .rst(rst),
   .cfgWr(cfgWr), .cfgSel(cfgSel), .cfgData(cfgData), .cfgAck(cfgAck),
   .cfgBad(cfgBad), .cmdValid(cmdValid), .cmdChar(cmdChar),
   .cmdLast(cmdLast), .cmdPort(cmdPort), .lockBusy(lockBusy),
   .lockPort(lockPort));
